//--- logic/chan_demux.sv
// Purpose: Input channel demultiplexer of the enhanced serial port
// Assumes: Serial bit clock is a separate domain; bus is a word-addressed peripheral port
// Notes:   Filled holding words cross to the system clock through a toggle handshake
//
// Contract
// - Sixteen 8-bit start fields, two per 16-bit register, even channel low.
// - Start value picks the frame bit where the sample begins, 0 to 255.
// - Length code gives 1,2,4,8 bits, transfer every 16,8,4,2 frames.
// - Length settings act only in frame mode; simple mode ignores them.
// - Valid bit per channel: 0 skips the channel, 1 extracts it.
// - Settings are reached only as memory-mapped peripheral locations.
`timescale 1ns/1ns
module chan_demux
  import chan_demux_pkg::*;
(
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_b,
  input  wire logic [chan_demux_pkg::ADDR_W-1:0] i_addr,
  input  wire logic                           i_wr,
  input  wire logic                           i_rd,
  input  wire logic [chan_demux_pkg::DATA_W-1:0] i_wdata,
  output logic      [chan_demux_pkg::DATA_W-1:0] o_rdata,
  output logic                                o_word_ready,
  input  wire logic                           i_bit_clk,
  input  wire logic                           i_frame_sync,
  input  wire logic                           i_serial_data
);
  import chan_demux_pkg::*;

  // ==========================================================================
  // Register file, system clock domain
  logic [7:0]  start_q   [NUM_CH];
  logic [31:0] length_q;
  logic [15:0] valid_q;
  logic [15:0] control_q;
  logic [15:0] hold_q    [NUM_CH];
  logic [15:0] fresh_q;
  logic [15:0] rdata_q;
  logic        word_ready_q;

  wire in_start  = i_addr >= START_BASE_ADDR && i_addr <= START_LAST_ADDR;
  wire in_data   = i_addr >= DATA_BASE_ADDR && i_addr <= DATA_LAST_ADDR;
  wire [2:0] start_idx = i_addr[2:0];
  wire [3:0] data_idx  = i_addr[3:0];

  // Write decode, one named strobe per register or register group; one read strobe for the data words
  wire wr_start   = i_wr && in_start;
  wire wr_len_lo  = i_wr && i_addr == LENGTH_LO_ADDR;
  wire wr_len_hi  = i_wr && i_addr == LENGTH_HI_ADDR;
  wire wr_valid   = i_wr && i_addr == VALID_ADDR;
  wire wr_control = i_wr && i_addr == CONTROL_ADDR;
  wire rd_data    = i_rd && in_data;

  // Read mux; unmapped locations read zero
  logic [15:0] rd_mux;
  always_comb begin
    rd_mux = 16'h0000;
    if (in_start)
      rd_mux = {start_q[{start_idx, 1'b1}], start_q[{start_idx, 1'b0}]};
    else if (i_addr == LENGTH_LO_ADDR) rd_mux = length_q[15:0];
    else if (i_addr == LENGTH_HI_ADDR) rd_mux = length_q[31:16];
    else if (i_addr == CONTROL_ADDR)   rd_mux = control_q;
    else if (i_addr == VALID_ADDR)     rd_mux = valid_q;
    else if (in_data)                  rd_mux = hold_q[data_idx];
  end

  // ==========================================================================
  // Crossing of filled holding words from the bit clock domain
  logic [19:0] cross_word;
  logic        cross_tog;
  logic        ack_tog;
  logic [2:0]  tog_sync_q;
  logic [1:0]  ack_sync_q;
  logic        fifo_in_valid;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [19:0] fifo_out_data;
  logic        ack_q;
  wire         new_word = tog_sync_q[2] != tog_sync_q[1];

  // Level sync of the request toggle; stage 0 is read only by stage 1
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) tog_sync_q <= 3'h0;
    else          tog_sync_q <= {tog_sync_q[1:0], cross_tog};
  end

  // Word is stable while toggles differ, so sampling it here is safe
  assign fifo_in_valid = new_word;

  word_fifo #(.WIDTH(20), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk       (i_clk),
    .i_rst_b     (i_rst_b),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .i_in_data   (cross_word),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (1'b1),
    .o_out_data  (fifo_out_data)
  );

  // Acknowledge only after the FIFO takes the word; a full FIFO stalls the link side
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) ack_q <= 1'b0;
    else if (new_word && fifo_in_ready) ack_q <= ~ack_q;
  end
  assign ack_tog = ack_q;

  // Register writes and holding-word capture
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      for (int c = 0; c < NUM_CH; c++) begin
        start_q[c] <= START_RESET[7:0];
        hold_q[c]  <= 16'h0000;
      end
      length_q     <= {LENGTH_RESET, LENGTH_RESET};
      valid_q      <= VALID_RESET;
      control_q    <= CONTROL_RESET;
      fresh_q      <= 16'h0000;
      rdata_q      <= 16'h0000;
      word_ready_q <= 1'b0;
    end else begin
      if (wr_start) begin
        start_q[{start_idx, 1'b0}] <= i_wdata[7:0];
        start_q[{start_idx, 1'b1}] <= i_wdata[15:8];
      end
      if (wr_len_lo)  length_q[15:0]  <= i_wdata;
      if (wr_len_hi)  length_q[31:16] <= i_wdata;
      if (wr_valid)   valid_q   <= i_wdata;
      if (wr_control) control_q <= i_wdata;
      if (fifo_out_valid)
        hold_q[fifo_out_data[19:16]] <= fifo_out_data[15:0];
      // Set wins over the read clear
      for (int c = 0; c < NUM_CH; c++)
        if (fifo_out_valid && fifo_out_data[19:16] == 4'(c)) fresh_q[c] <= 1'b1;
        else if (rd_data && data_idx == 4'(c))             fresh_q[c] <= 1'b0;
      rdata_q      <= rd_mux;
      word_ready_q <= |fresh_q;
    end
  end

  assign o_rdata      = rdata_q;
  assign o_word_ready = word_ready_q;

  // ==========================================================================
  // Link domain: settings are quasi-static; enable and mode are synchronised as levels, start, length and valid are read directly
  logic [1:0]  en_s_q;
  logic [1:0]  mode_s_q;
  logic [1:0]  sd_s_q;
  logic [1:0]  fs_s_q;
  logic [1:0]  ack_s_q;
  logic        fs_prev_q;
  logic [7:0]  bit_pos_q;
  logic [15:0] shreg_q   [NUM_CH];
  logic [4:0]  cnt_q     [NUM_CH];
  logic [7:0]  got_q     [NUM_CH];
  logic [15:0] pend_q;
  logic [15:0] pend_word [NUM_CH];
  logic        busy_q;
  logic [19:0] xword_q;
  logic        xtog_q;

  wire frame_start = fs_s_q[1] && !fs_prev_q;
  wire frame_mode  = !mode_s_q[1];

  always_ff @(posedge i_bit_clk) begin
    en_s_q   <= {en_s_q[0],   control_q[CTRL_ENABLE_BIT]};
    mode_s_q <= {mode_s_q[0], control_q[CTRL_MODE_BIT]};
    sd_s_q   <= {sd_s_q[0],   i_serial_data};
    fs_s_q   <= {fs_s_q[0],   i_frame_sync};
    ack_s_q  <= {ack_s_q[0],  ack_tog};
  end

  // Per-channel sample length; simple mode always takes one bit
  function automatic logic [3:0] sample_bits(input logic [1:0] code);
    case (code)
      LEN_1BIT: sample_bits = 4'h1;
      LEN_2BIT: sample_bits = 4'h2;
      LEN_4BIT: sample_bits = 4'h4;
      default:  sample_bits = 4'h8;
    endcase
  endfunction : sample_bits

  // ==========================================================================
  // Reset crosses into the link domain through two flops; release waits two bit clocks
  logic [1:0] rst_s_q;
  wire        link_rst_b = rst_s_q[1];
  always_ff @(posedge i_bit_clk) begin
    rst_s_q <= {rst_s_q[0], i_rst_b};
  end

  // Frame bit counter and per-channel gathering
  always_ff @(posedge i_bit_clk) begin
    if (!link_rst_b) begin
      fs_prev_q <= 1'b0;
      bit_pos_q <= 8'h00;
      pend_q    <= 16'h0000;
      busy_q    <= 1'b0;
      xtog_q    <= 1'b0;
      xword_q   <= 20'h00000;
      for (int c = 0; c < NUM_CH; c++) begin
        shreg_q[c]   <= 16'h0000;
        cnt_q[c]     <= 5'h00;
        got_q[c]     <= 8'h00;
        pend_word[c] <= 16'h0000;
      end
    end else begin
      fs_prev_q <= fs_s_q[1];
      bit_pos_q <= frame_start ? 8'h01 : bit_pos_q + 8'h01;
      for (int c = 0; c < NUM_CH; c++) begin
        logic [3:0] len;
        logic [7:0] pos;
        len = frame_mode ? sample_bits(length_q[2*c +: 2]) : 4'h1;
        pos = frame_start ? 8'h00 : bit_pos_q;
        if (frame_start) got_q[c] <= 8'h00;
        if (en_s_q[1] && valid_q[c] && pos >= start_q[c]
            && (frame_start ? 8'h00 : got_q[c]) < {4'h0, len}) begin
          shreg_q[c] <= {shreg_q[c][14:0], sd_s_q[1]};
          got_q[c]   <= (frame_start ? 8'h00 : got_q[c]) + 8'h01;
          if (cnt_q[c] == 5'd15) begin
            cnt_q[c]     <= 5'h00;
            pend_q[c]    <= 1'b1;
            pend_word[c] <= {shreg_q[c][14:0], sd_s_q[1]};        // full word
          end else begin
            cnt_q[c] <= cnt_q[c] + 5'h01;
          end
        end
      end
      // Launch one pending word when the previous crossing is acknowledged
      if (busy_q && ack_s_q[1] == xtog_q) busy_q <= 1'b0;
      if (!busy_q) begin
        for (int c = NUM_CH-1; c >= 0; c--)
          if (pend_q[c]) begin
            xword_q <= {4'(c), pend_word[c]};
          end
        if (|pend_q) begin
          busy_q <= 1'b1;
          xtog_q <= ~xtog_q;
          for (int c = 0; c < NUM_CH; c++)
            if (pend_q[c] && (pend_q & ((16'h0001 << c) - 16'h0001)) == 16'h0000)
              pend_q[c] <= 1'b0;
        end
      end
    end
  end

  assign cross_word = xword_q;
  assign cross_tog  = xtog_q;

  // ==========================================================================
  // Checks
  start_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_wr && i_addr == START_BASE_ADDR |=> start_q[0] == $past(i_wdata[7:0])
      && start_q[1] == $past(i_wdata[15:8])) else $error("start field write lost");
  valid_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_wr && i_addr == VALID_ADDR |=> valid_q == $past(i_wdata)) else $error("valid vector write lost");
  read_back_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_addr == LENGTH_HI_ADDR && !i_wr |=> o_rdata == length_q[31:16]) else $error("length readback wrong");
  unmapped_zero_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    i_addr < START_BASE_ADDR |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
  skip_channel_a: assert property (@(posedge i_bit_clk) disable iff (!i_rst_b)
    !valid_q[4] && !pend_q[4] |=> !pend_q[4]) else $error("disabled channel produced word");
  len_code_a: assert property (@(posedge i_bit_clk) disable iff (!i_rst_b)
    frame_mode && length_q[5:4] == LEN_2BIT |-> got_q[2] <= 8'h02) else $error("sample length exceeded");
  before_start_a: assert property (@(posedge i_bit_clk) disable iff (!i_rst_b)
    !frame_start && bit_pos_q < start_q[0] |=> $stable(shreg_q[0]))
    else $error("bit taken before start position");
  cross_hold_a: assert property (@(posedge i_bit_clk) disable iff (!i_rst_b)
    busy_q && ack_s_q[1] != xtog_q |=> $stable(xword_q))
    else $error("crossing word changed in flight");
  length_write_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_len_lo |=> length_q[15:0] == $past(i_wdata))
    else $error("length write lost");
  hold_capture_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fifo_out_valid |=> hold_q[$past(fifo_out_data[19:16])] == $past(fifo_out_data[15:0]))
    else $error("holding word not captured");
  fresh_set_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    fifo_out_valid |=> fresh_q[$past(fifo_out_data[19:16])])
    else $error("fresh flag not set");
  read_clear_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rd_data && !fifo_out_valid |=> !fresh_q[$past(data_idx)])
    else $error("read did not clear fresh flag");
  ready_follow_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    1'b1 |=> o_word_ready == $past(|fresh_q))
    else $error("word ready out of step");
  ack_after_push_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    new_word && fifo_in_ready |=> ack_q != $past(ack_q))
    else $error("crossing not acknowledged");
  simple_one_a: assert property (@(posedge i_bit_clk) disable iff (!i_rst_b)
    !frame_mode && !frame_start |-> got_q[0] <= 8'h01) else $error("simple mode took more bits");
  gather_a: assert property (@(posedge i_bit_clk) disable iff (!i_rst_b)
    cnt_q[0] == 5'd15 && $changed(cnt_q[0]) |-> ##[1:300] $past(pend_q[0]) || cnt_q[0] == 5'd0)
    else $error("full word not pended");
  cov_word_c:  cover property (@(posedge i_clk) disable iff (!i_rst_b) fifo_out_valid);
  cov_full_c:  cover property (@(posedge i_clk) disable iff (!i_rst_b) !fifo_in_ready);
  cov_frame_c: cover property (@(posedge i_bit_clk) disable iff (!i_rst_b) frame_start && frame_mode);
  // Simple mode and a data read while some word is fresh
  cov_simple_c: cover property (@(posedge i_bit_clk) disable iff (!i_rst_b) frame_start && !frame_mode);
  cov_clear_c:  cover property (@(posedge i_clk) disable iff (!i_rst_b) rd_data && |fresh_q);
endmodule : chan_demux

//--- logic/chan_demux_pkg.sv
// Purpose: Shared constants for the serial input channel demultiplexer
// Assumes: Peripheral word addresses, 16-bit register data
// Notes:   Offsets are word addresses in the peripheral range
package chan_demux_pkg;
  // ==========================================================================
  // Register map
  localparam int          ADDR_W          = 20;
  localparam int          DATA_W          = 16;
  localparam logic [19:0] START_BASE_ADDR = 20'hE0010;
  localparam logic [19:0] START_LAST_ADDR = 20'hE0017;
  localparam logic [19:0] LENGTH_LO_ADDR  = 20'hE0018;
  localparam logic [19:0] LENGTH_HI_ADDR  = 20'hE0019;
  localparam logic [19:0] CONTROL_ADDR    = 20'hE001A;
  localparam logic [19:0] VALID_ADDR      = 20'hE001B;
  localparam logic [19:0] DATA_BASE_ADDR  = 20'hE0020;
  localparam logic [19:0] DATA_LAST_ADDR  = 20'hE002F;
  // ==========================================================================
  // Reset values, field positions, channel count and FIFO depth
  localparam logic [15:0] START_RESET     = 16'h0000;
  localparam logic [15:0] LENGTH_RESET    = 16'h0000;
  localparam logic [15:0] VALID_RESET     = 16'h0000;
  localparam logic [15:0] CONTROL_RESET   = 16'h0000;
  localparam int          CTRL_MODE_BIT   = 8;
  localparam int          CTRL_ENABLE_BIT = 2;
  localparam int          NUM_CH          = 16;
  localparam int          FIFO_DEPTH      = 8;
  // Sample length codes
  localparam logic [1:0]  LEN_1BIT        = 2'h0;
  localparam logic [1:0]  LEN_2BIT        = 2'h1;
  localparam logic [1:0]  LEN_4BIT        = 2'h2;
  localparam logic [1:0]  LEN_8BIT        = 2'h3;
endpackage : chan_demux_pkg

//--- logic/word_fifo.sv
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty are exact; no write when full
`timescale 1ns/1ns
module word_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_b,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  // ==========================================================================
  // Status from pointer difference
  assign o_in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_q != rd_q;
  assign o_out_data  = mem[rd_q[AW-1:0]];

  // Pointers and storage
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem[wr_q[AW-1:0]] <= i_in_data;
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (wr_q - rd_q) <= (AW+1)'(DEPTH)) else $error("fifo overfilled");
endmodule : word_fifo

//--- bench/serial_line_model.sv
// Purpose: Far-side serial line: bit clock, frame sync and data for the demux
// Assumes: Data and sync change on the falling bit clock edge, sampled on the rising one
// Notes:   Bit clock stands still in the gap after slow frames; idle data shows the inverse of the last bit
`timescale 1ns/1ns
module serial_line_model #(
  parameter int FRAME_BITS = 32,
  parameter int HALF_NS    = 3
) (
  output logic o_bit_clk,
  output logic o_frame_sync,
  output logic o_serial_data
);
  initial begin
    o_bit_clk     = 1'b0;
    o_frame_sync  = 1'b0;
    o_serial_data = 1'b0;
  end

  // ==========================================================================
  // One bit period: drive, then rising and falling clock edge
  task automatic bit_out(input logic sync, input logic data);
    o_frame_sync  = sync;
    o_serial_data = data;
    #HALF_NS o_bit_clk = 1'b1;
    #HALF_NS o_bit_clk = 1'b0;
  endtask : bit_out

  // Free clocks with sync low, so the link side sees its reset
  task automatic idle_clocks(input int n);
    for (int i = 0; i < n; i++) bit_out(1'b0, i[0]);
    o_serial_data = ~o_serial_data;
  endtask : idle_clocks

  // ==========================================================================
  // Frame: sync high with bit 0; trailing clocks flush the link side's sync delay
  task automatic send_frame(input logic [FRAME_BITS-1:0] frm, input int gap_bits);
    #1;
    for (int p = 0; p < FRAME_BITS; p++) bit_out(p == 0, frm[p]);
    idle_clocks(4);
    #(gap_bits * 2 * HALF_NS);  // Slow partner: clock stays still in the gap
  endtask : send_frame
endmodule : serial_line_model

//--- bench/chan_demux_tb.sv
// Purpose: Self-checking bench for the serial input channel demultiplexer
// Assumes: Word-addressed register port, read data one cycle after the address
// Notes:   Expected holding words come from a small shift model kept here
`timescale 1ns/1ns
module chan_demux_tb;
  import chan_demux_pkg::*;
  localparam int NB = 32;
  logic              i_clk;
  logic              i_rst_b;
  logic              i_wr;
  logic              i_rd;
  logic              bclk;
  logic              fsync;
  logic              sdata;
  logic              ready;
  logic [ADDR_W-1:0] i_addr;
  logic [DATA_W-1:0] i_wdata;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] got;
  logic [15:0]       sh[5];
  logic [15:0]       hold[5];
  logic [NB-1:0]     frm;
  logic [15:0]       vv;
  logic              fresh;
  int                cnt[5];
  int                st[5] = '{2, 12, 20, 26, 30};
  int                ln[5] = '{8, 4, 2, 1, 8};
  int                err_total;
  int                n_compared;

  chan_demux u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
                    .i_wdata(i_wdata), .o_rdata(rdata), .o_word_ready(ready), .i_bit_clk(bclk),
                    .i_frame_sync(fsync), .i_serial_data(sdata));
  serial_line_model #(.FRAME_BITS(NB)) u_line (.o_bit_clk(bclk), .o_frame_sync(fsync), .o_serial_data(sdata));

  // ==========================================================================
  // Clock and shared tasks
  initial i_clk = 1'b0;
  always #2 i_clk = ~i_clk;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(negedge i_clk);
    i_addr  = a;
    i_wdata = d;
    i_wr    = 1'b1;
    @(negedge i_clk);
    i_wr = 1'b0;
  endtask : wr

  // Data registered on the edge after the address, sampled half a cycle later
  task automatic rd(input logic [19:0] a, output logic [15:0] d);
    @(negedge i_clk);
    i_addr = a;
    i_rd   = 1'b1;
    @(negedge i_clk);
    d    = rdata;
    i_rd = 1'b0;
  endtask : rd

  task automatic wrap_up;
    $display("mismatches=%0d compares=%0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Watchdog: the tests need about 13 us; a hang is cut at 100 us
  initial begin
    #100000;
    err_total++;
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    i_rst_b = 1'b0; i_wr = 1'b0; i_rd = 1'b0; i_addr = '0; i_wdata = '0;
    err_total = 0; n_compared = 0;
    fork
      u_line.idle_clocks(6);
      repeat (12) @(negedge i_clk);
    join
    i_rst_b = 1'b1;
    // Reset values of all settings
    for (int a = 0; a < 12; a++) begin
      rd(START_BASE_ADDR + 20'(a), got); chk(got, 16'h0000);
    end
    // Start fields, boundary values 00 and FF in the last register
    for (int a = 0; a < 8; a++) wr(START_BASE_ADDR + 20'(a), (a == 7) ? 16'hFF00 : {8'(a + 16), 8'(a)});
    for (int a = 0; a < 8; a++) begin
      rd(START_BASE_ADDR + 20'(a), got); chk(got, (a == 7) ? 16'hFF00 : {8'(a + 16), 8'(a)});
    end
    wr(LENGTH_HI_ADDR, 16'hA5A5);
    rd(LENGTH_HI_ADDR, got); chk(got, 16'hA5A5);
    // Unmapped places ignore writes and read zero
    wr(20'hE001C, 16'hFFFF);
    rd(20'hE001C, got); chk(got, 16'h0000);
    rd(20'hE000F, got); chk(got, 16'h0000);
    // Frame mode: ch0..3 at 8,4,2,1 bits; ch4 configured but not valid
    wr(START_BASE_ADDR, 16'h0C02);
    wr(START_BASE_ADDR + 20'h1, 16'h1A14);
    wr(START_BASE_ADDR + 20'h2, 16'h001E);
    wr(LENGTH_LO_ADDR, 16'h031B);
    vv = 16'h000F;
    wr(VALID_ADDR, vv);
    wr(CONTROL_ADDR, 16'h0004);
    for (int c = 0; c < 5; c++) begin
      sh[c] = 16'h0000; hold[c] = 16'h0000; cnt[c] = 0;
    end
    // Sixteen frames per mode, prompt and slow in turn; simple mode takes one bit of channel 0
    for (int m = 0; m < 2; m++) begin
    if (m == 1) begin
      vv = 16'h0001;
      wr(VALID_ADDR, vv);
      wr(CONTROL_ADDR, 16'h0104);
    end
    for (int f = 0; f < 16; f++) begin
      frm = 32'h6B3D_94E1 ^ {4{8'(f * 37)}};
      u_line.send_frame(frm, (f % 2) * 20);
      fresh = 1'b0;
      for (int c = 0; c < 5; c++) begin
        if (vv[c]) begin
          for (int k = 0; k < ((m == 1) ? 1 : ln[c]); k++) begin
            sh[c] = {sh[c][14:0], frm[st[c] + k]};
            cnt[c]++;
            if (cnt[c] == 16) begin
              hold[c] = sh[c]; cnt[c] = 0; fresh = 1'b1;
            end
          end
        end
      end
      repeat (20) @(negedge i_clk);
      chk({15'h0000, ready}, {15'h0000, fresh});
      for (int c = 0; c < 5; c++) begin
        rd(DATA_BASE_ADDR + 20'(c), got); chk(got, hold[c]);
      end
      repeat (2) @(negedge i_clk);
      chk({15'h0000, ready}, 16'h0000);
    end
    end
    wrap_up();
  end
endmodule : chan_demux_tb
